/* hdl/amcc_ctrl.sv */
// Mode pin decode, sample strobes and calibration control with AHB-Lite registers
`include "amcc_regs.svh"

module amcc_ctrl
   import amcc_pkg::*;
#(
   parameter logic [15:0] DLY_SHORT    = `AMCC_DLY_SHORT,
   parameter logic [15:0] DLY_LONG     = `AMCC_DLY_LONG,
   parameter logic [15:0] CAL_LEN      = `AMCC_CAL_LEN,
   parameter logic [15:0] CAL_LOW_MIN  = `AMCC_CAL_LOW_MIN,
   parameter logic [15:0] CAL_HIGH_MIN = `AMCC_CAL_HIGH_MIN
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Strap and clock pins
   input  wire logic [1:0]  fullScaleRangeSelect,
   input  wire logic [1:0]  calDelaySelect,
   input  wire logic        calRequestPin,
   input  wire logic        sampleClkPin,
   // Status and mode outputs
   output logic             calibrationRunning,
   output logic             extendedControlEnable,
   output logic             dualEdgeSampling,
   output logic             serialChipSelectN,
   output logic             sampleStrobeI,
   output logic             sampleStrobeQ,
   output logic      [7:0]  fullScaleCode
);

   amcc_regs_t r;
   amcc_regs_t n;

   logic [1:0] fsrPin;
   logic [1:0] dlyPin;
   logic       calPin;
   logic       clkNow;
   logic       fallEdge;
   logic       riseEdge;
   logic       calTrig;
   logic       ext;
   logic       addrPh;
   logic [15:0] waitLen;

   assign fsrPin   = r.sy2[`AMCC_SY_FSR];
   assign dlyPin   = r.sy2[`AMCC_SY_DLY];
   assign calPin   = r.sy2[`AMCC_SY_CAL];
   assign clkNow   = r.sy2[`AMCC_SY_CLK];
   // Edges are ignored while the synchroniser refills after reset
   assign fallEdge = r.clkPrev & ~clkNow & (r.st != SETTLE);
   assign riseEdge = ~r.clkPrev & clkNow & (r.st != SETTLE);
   assign ext      = (fsrPin == `AMCC_PIN_MID);
   assign calTrig  = r.lowOk & calPin & fallEdge & (r.highCnt + 16'h0001 >= CAL_HIGH_MIN);
   assign addrPh   = hsel & htrans[1] & hready;
   assign waitLen  = r.dlySel ? DLY_LONG : DLY_SHORT;

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      n = r;
      n.sy1     = {sampleClkPin, calRequestPin, calDelaySelect, fullScaleRangeSelect};
      n.sy2     = r.sy1;
      n.clkPrev = clkNow;

      // Mode decode
      n.extMode  = ext;
      n.desMode  = (dlyPin == `AMCC_PIN_MID);
      n.chipSelN = ext ? (dlyPin != `AMCC_PIN_LOW) : 1'b1;
      n.fsrCode  = ext ? r.fsAdj : ((fsrPin == `AMCC_PIN_HIGH) ? `AMCC_FSR_HIGH : `AMCC_FSR_LOW);

      // Sample strobes
      n.strobeI = fallEdge | (n.desMode & riseEdge);
      n.strobeQ = fallEdge & ~n.desMode;

      // Calibrate pin low then high detector
      if (fallEdge) begin
         if (!calPin) begin
            n.highCnt = 16'h0000;
            if (r.lowCnt != 16'hffff) begin
               n.lowCnt = r.lowCnt + 16'h0001;
            end
            if (r.lowCnt + 16'h0001 >= CAL_LOW_MIN) begin
               n.lowOk = 1'b1;
            end
         end else begin
            n.lowCnt = 16'h0000;
            if (r.lowOk && r.highCnt != 16'hffff) begin
               n.highCnt = r.highCnt + 16'h0001;
            end
         end
      end

      // Calibration sequencer
      case (r.st)
         SETTLE: begin
            n.settle = r.settle + 2'h1;
            if (r.settle == 2'h3) begin
               n.dlySel = ~ext & (dlyPin == `AMCC_PIN_HIGH);
               n.cnt    = 16'h0000;
               n.st     = PWR_WAIT;
            end
         end
         PWR_WAIT: begin
            if (fallEdge) begin
               n.cnt = r.cnt + 16'h0001;
               if (r.cnt + 16'h0001 >= waitLen) begin
                  n.cnt = 16'h0000;
                  n.st  = CALIB;
               end
            end
         end
         CALIB: begin
            if (fallEdge) begin
               n.cnt = r.cnt + 16'h0001;
               if (r.cnt + 16'h0001 >= CAL_LEN) begin
                  n.cnt  = 16'h0000;
                  n.done = 1'b1;
                  n.st   = IDLE;
               end
            end
         end
         IDLE: begin
            if (calTrig || r.swCal) begin
               n.cnt     = 16'h0000;
               n.swCal   = 1'b0;
               n.lowOk   = 1'b0;
               n.highCnt = 16'h0000;
               n.st      = CALIB;
            end
         end
         default: begin
            n.st = SETTLE;
         end
      endcase
      n.calibration_running = (n.st == CALIB);

      // Bus data phase write
      if (r.ahbWr) begin
         case (r.ahbAddr)
            `AMCC_OFS_CTRL: begin
               if (hwdata[`AMCC_CTRL_CAL] && ext) begin
                  n.swCal = 1'b1;
               end
            end
            `AMCC_OFS_FSADJ: begin
               n.fsAdj = hwdata[`AMCC_FSADJ_RNG];
            end
            default: begin
            end
         endcase
      end

      // Bus address phase
      n.ahbWr = addrPh & hwrite;
      n.ahbAddr = haddr[7:0];
      if (addrPh && !hwrite) begin
         n.rdata = 32'h0000_0000;
         case (haddr[7:0])
            `AMCC_OFS_CTRL: begin
               n.rdata[`AMCC_CTRL_CAL] = r.swCal;
            end
            `AMCC_OFS_FSADJ: begin
               n.rdata[`AMCC_FSADJ_RNG] = r.fsAdj;
            end
            `AMCC_OFS_STATUS: begin
               n.rdata[`AMCC_ST_RUN]  = r.calibration_running;
               n.rdata[`AMCC_ST_EXT]  = r.extMode;
               n.rdata[`AMCC_ST_DES]  = r.desMode;
               n.rdata[`AMCC_ST_DLY]  = r.dlySel;
               n.rdata[`AMCC_ST_DONE] = r.done;
            end
            default: begin
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         r          <= '0;
         r.st       <= SETTLE;
         r.fsAdj    <= `AMCC_FSADJ_RST;
         r.chipSelN <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign hrdata                = r.rdata;
   assign hreadyout             = ~rst;
   assign hresp                 = 1'b0;
   assign calibrationRunning    = r.calibration_running;
   assign extendedControlEnable = r.extMode;
   assign dualEdgeSampling      = r.desMode;
   assign serialChipSelectN     = r.chipSelN;
   assign sampleStrobeI         = r.strobeI;
   assign sampleStrobeQ         = r.strobeQ;
   assign fullScaleCode         = r.fsrCode;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence sSettleEnd;
      (r.st == SETTLE) && (r.settle == 2'h3);
   endsequence

   sequence sCalEnter;
      (r.st == IDLE) ##1 (r.st == CALIB);
   endsequence

   a_dly_pin_used: assert property ((sSettleEnd and !ext) |=> r.dlySel == $past(dlyPin == `AMCC_PIN_HIGH))
      else $error("Delay select not taken from pin");
   a_dly_forced_zero: assert property ((sSettleEnd and ext) |=> !r.dlySel && r.st == PWR_WAIT)
      else $error("Delay select not zero in extended mode");
   a_des_q_ignored: assert property (dlyPin == `AMCC_PIN_MID |=> dualEdgeSampling && !sampleStrobeQ)
      else $error("Dual edge mode wrong or Q sampled");
   a_fall_sample: assert property (fallEdge |=> sampleStrobeI ##1 !sampleStrobeI)
      else $error("No sample strobe on falling edge");
   a_run_tracks: assert property (calibrationRunning == (r.st == CALIB))
      else $error("Calibration running flag wrong");
   a_run_ends: assert property (calibrationRunning && !(r.st == CALIB && n.st == CALIB) |=> !calibrationRunning)
      else $error("Calibration running not cleared");
   a_fsr_source: assert property (!ext |=> fullScaleCode == ($past(fsrPin) == `AMCC_PIN_HIGH ? `AMCC_FSR_HIGH : `AMCC_FSR_LOW))
      else $error("Range not taken from pin");
   a_ext_enable: assert property (ext |=> extendedControlEnable && fullScaleCode == $past(r.fsAdj))
      else $error("Extended control not entered");
   a_cmd_cause: assert property (sCalEnter |-> $past(calTrig) || $past(r.swCal))
      else $error("Calibration started without request");

endmodule // amcc_ctrl

/* hdl/amcc_pkg.sv */
// Types for the converter mode pin and calibration control block
package amcc_pkg;
   typedef enum logic [2:0] {
      SETTLE,
      PWR_WAIT,
      CALIB,
      IDLE
   } amcc_state_t;

   typedef struct packed {
      logic [5:0]  sy1;
      logic [5:0]  sy2;
      logic        clkPrev;
      amcc_state_t st;
      logic [15:0] cnt;
      logic [1:0]  settle;
      logic [15:0] lowCnt;
      logic        lowOk;
      logic [15:0] highCnt;
      logic        dlySel;
      logic        done;
      logic        swCal;
      logic [7:0]  fsAdj;
      logic        ahbWr;
      logic [7:0]  ahbAddr;
      logic [31:0] rdata;
      logic        calibration_running;
      logic        strobeI;
      logic        strobeQ;
      logic        desMode;
      logic        extMode;
      logic        chipSelN;
      logic [7:0]  fsrCode;
   } amcc_regs_t;
endpackage

/* hdl/amcc_regs.svh */
// Constants for the converter mode pin and calibration control block
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
`ifndef AMCC_REGS_SVH
`define AMCC_REGS_SVH
// Three-level pin codes
`define AMCC_PIN_LOW      2'h0
`define AMCC_PIN_HIGH     2'h1
`define AMCC_PIN_MID      2'h2
// Synchroniser bit positions
`define AMCC_SY_FSR       1:0
`define AMCC_SY_DLY       3:2
`define AMCC_SY_CAL       4
`define AMCC_SY_CLK       5
// Register byte offsets
`define AMCC_OFS_CTRL     8'h00
`define AMCC_OFS_FSADJ    8'h04
`define AMCC_OFS_STATUS   8'h08
// Field positions
`define AMCC_CTRL_CAL     0
`define AMCC_FSADJ_RNG    7:0
`define AMCC_ST_RUN       0
`define AMCC_ST_EXT       1
`define AMCC_ST_DES       2
`define AMCC_ST_DLY       3
`define AMCC_ST_DONE      4
// Reset values and range codes
`define AMCC_FSADJ_RST    8'h80
`define AMCC_FSR_LOW      8'h00
`define AMCC_FSR_HIGH     8'hff
// Default counts in input clock cycles
`define AMCC_DLY_SHORT    16'h0020
`define AMCC_DLY_LONG     16'h0400
`define AMCC_CAL_LEN      16'h0040
`define AMCC_CAL_LOW_MIN  16'h0050
`define AMCC_CAL_HIGH_MIN 16'h0050
`endif

/* sim/amcc_host_model.sv */
// Host side model: free running input clock and calibrate pin
module amcc_host_model #(
   parameter int LOW_N = 4
) (
   // Clock and trigger
   input  wire logic clk,
   input  wire logic calGo,
   // Strap and clock pins
   output logic      sampleClkPin,
   output logic      calRequestPin
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial sampleClkPin = 1'b1;
   initial calRequestPin = 1'b1;
   // Input clock period is eight system clocks
   always @(posedge clk) begin
      n <= n + 1;
      if (n % 4 == 3) sampleClkPin <= ~sampleClkPin;
   end
   // Low longer than the minimum, then high from then on
   always @(posedge calGo) begin
      calRequestPin <= 1'b0;
      repeat (LOW_N * 8) @(posedge clk);
      calRequestPin <= 1'b1;
   end
endmodule // amcc_host_model

/* sim/tb_top.sv */
// Testbench for the converter mode pin and calibration block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, hwrite = 0, calGo = 0, rdPh = 0, sPrev = 1, hsel = 1;
   logic [2:0] hsize = 3'h2;
   logic [1:0] htrans = 0, fsrPin = 1, dlyPin = 1;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h7f2ecf4a;
   logic hreadyout, hresp, calibration_running, ext, des, csN, stI, stQ, sclk, creq;
   logic [7:0] fsc;
   logic [31:0] expQ[$];
   int num_errors = 0, tests_run = 0, nI = 0, nQ = 0, sf = 0, t, len;
   always #5 clk = ~clk;
   amcc_ctrl #(.DLY_SHORT(16'h0004), .DLY_LONG(16'h0008), .CAL_LEN(16'h0004),
      .CAL_LOW_MIN(16'h0003), .CAL_HIGH_MIN(16'h0003)) i_amcc_ctrl (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .fullScaleRangeSelect(fsrPin), .calDelaySelect(dlyPin),
      .calRequestPin(creq), .sampleClkPin(sclk), .calibrationRunning(calibration_running),
      .extendedControlEnable(ext), .dualEdgeSampling(des),
      .serialChipSelectN(csN), .sampleStrobeI(stI), .sampleStrobeQ(stQ),
      .fullScaleCode(fsc));
   amcc_host_model i_amcc_host_model (.clk(clk), .calGo(calGo),
      .sampleClkPin(sclk), .calRequestPin(creq));
   //------------------------------------------------------------
   // Checking
   //------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      sPrev <= sclk;
      sf <= (sPrev && !sclk) ? 0 : sf + 1;
      if (stI === 1'b1) nI++;
      if (stQ === 1'b1) nQ++;
      if (stI === 1'b1 && des === 1'b0) chk("strobePhase", 1, sf >= 2 && sf <= 6);
      if (rdPh && hreadyout === 1'b1) chk("hrdata", expQ.pop_front(), hrdata);
      if (rdPh && hreadyout === 1'b1) chk("hresp", 0, hresp);
   end
   //------------------------------------------------------------
   // Stimulus
   //------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rdPh <= ~w;
      if (!w) expQ.push_back(d);
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdPh <= 1'b0;
   endtask
   task automatic powerup(input logic [1:0] f, input logic [1:0] d);
      fsrPin <= f;
      dlyPin <= d;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t = 0;
      len = 0;
      while (calibration_running !== 1'b1 && t < 400) begin
         @(posedge clk);
         t++;
      end
      while (calibration_running === 1'b1 && len < 400) begin
         @(posedge clk);
         len++;
      end
   endtask
   task automatic window(input logic d);
      #1;
      nI = 0;
      nQ = 0;
      repeat (80) @(posedge clk);
      chk("nI", 1, d ? nI >= 19 && nI <= 21 : nI >= 9 && nI <= 11);
      chk("nQ", 1, d ? nQ == 0 : nQ >= 9 && nQ <= 11);
   endtask
   task automatic waitRun(input int lim);
      t = 0;
      while (calibration_running !== 1'b1 && t < lim) begin
         @(posedge clk);
         t++;
      end
   endtask
   initial begin
      powerup(2'h1, 2'h1);
      chk("longWait", 1, t >= 58 && t <= 95);
      chk("calLen", 1, len >= 24 && len <= 40);
      chk("range", 8'hff, fsc);
      chk("ext", 0, ext);
      bus(0, 32'h08, 32'h18);
      bus(0, 32'h0c, 32'h0);
      bus(0, 32'h04, 32'h80);
      bus(1, 32'h00, 32'h1);
      repeat (20) @(posedge clk);
      chk("calRefused", 0, calibration_running);
      calGo <= 1'b1;
      waitRun(300);
      chk("pinCal", 1, t >= 40 && t <= 100);
      fsrPin <= 2'h0;
      window(1'b0);
      chk("rangeLow", 8'h00, fsc);
      fsrPin <= 2'h2;
      dlyPin <= 2'h0;
      repeat (40) @(posedge clk);
      chk("ext", 1, ext);
      chk("csN", 0, csN);
      seed = nxt(seed);
      bus(1, 32'h04, seed & 32'hff);
      bus(0, 32'h04, seed & 32'hff);
      chk("rangeAdj", seed[7:0], fsc);
      hsel <= 1'b0;
      bus(1, 32'h04, ~seed & 32'hff);
      hsel <= 1'b1;
      bus(0, 32'h04, seed & 32'hff);
      bus(1, 32'h00, 32'h1);
      waitRun(40);
      chk("regCal", 1, t < 40);
      dlyPin <= 2'h2;
      repeat (40) @(posedge clk);
      chk("des", 1, des);
      window(1'b1);
      bus(0, 32'h08, 32'h1e);
      powerup(2'h2, 2'h1);
      chk("shortWait", 1, t >= 24 && t <= 52);
      bus(0, 32'h08, 32'h12);
      chk("csN", 1, csN);
      complete_run;
   end
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      complete_run;
   end
endmodule // tb_top
